// [afs_pkg.sv]
// Constants and types of the serial audio frame formatter
package afs_pkg;
   localparam int POS_W = 10;
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_OFS1 = 3'h1;
   localparam logic [2:0] REG_OFS2 = 3'h2;
   localparam logic [2:0] REG_LEFT = 3'h3;
   localparam logic [2:0] REG_RIGHT = 3'h4;
   localparam logic [2:0] REG_STAT = 3'h5;
   localparam logic [POS_W-1:0] POS_MAX = 10'h3FF;
   localparam logic [POS_W-1:0] POS_ONE = 10'h001;

   typedef logic [POS_W:0] afs_ext_t;

   typedef enum logic [1:0] {
      FR_RJ = 2'h0,
      FR_LJ = 2'h1,
      FR_I2S = 2'h2,
      FR_DSP = 2'h3
   } afs_frame_e;

   typedef struct packed {
      logic bclk_inv;
      logic tri_en;
      logic slot_en;
      logic swap;
      logic [1:0] wlen;
      afs_frame_e mode;
   } afs_ctrl_s;

   localparam afs_ctrl_s CTRL_RST = 8'h41;

   typedef struct packed {
      logic bclk_m;
      logic bclk_s;
      logic bclk_d;
      logic wclk_m;
      logic wclk_s;
      logic wclk_d;
      afs_ctrl_s ctrl;
      logic [7:0] ofs1;
      logic [7:0] ofs2;
      logic [31:0] left;
      logic [31:0] right;
      logic [31:0] sh_l;
      logic [31:0] sh_r;
      logic [POS_W-1:0] pos_half;
      logic [POS_W-1:0] pos_frame;
      logic [POS_W-1:0] len_hi;
      logic [POS_W-1:0] len_lo;
      logic [POS_W-1:0] frame_len;
      logic [15:0] frame_cnt;
      logic dout;
      logic oe;
      logic [31:0] rdata;
   } afs_state_s;

   localparam afs_state_s ST_RST = '{ctrl: CTRL_RST, pos_half: POS_MAX,
      pos_frame: POS_MAX, default: '0};

   // Word length in bit clocks
   function automatic afs_ext_t afs_wlen(input logic [1:0] code);
      case (code)
         2'h0: afs_wlen = 11'h010;
         2'h1: afs_wlen = 11'h014;
         2'h2: afs_wlen = 11'h018;
         default: afs_wlen = 11'h020;
      endcase
   endfunction : afs_wlen
endpackage : afs_pkg

// [afs_formatter.sv]
// Serial audio frame formatter, transmit side
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module afs_formatter (
   input wire logic SYS_CLK_I,
   input wire logic NRST_I,
   input wire logic CE_I,
   input wire logic BCLK_I,
   input wire logic WCLK_I,
   input wire logic [2:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   output logic DOUT_O,
   output logic DOUT_OE_O
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic in_win(input afs_pkg::afs_ext_t pos,
         input afs_pkg::afs_ext_t st, input afs_pkg::afs_ext_t wl);
      in_win = (pos >= st) && (pos < st + wl);
   endfunction : in_win

   // MSB first: position st carries bit wl-1
   function automatic logic bit_of(input logic [31:0] smp,
         input afs_pkg::afs_ext_t pos, input afs_pkg::afs_ext_t st,
         input afs_pkg::afs_ext_t wl);
      afs_pkg::afs_ext_t k;
      k = wl - 11'h001 - (pos - st);
      bit_of = smp[k[4:0]];
   endfunction : bit_of

   function automatic logic [afs_pkg::POS_W-1:0] sat_inc(
         input logic [afs_pkg::POS_W-1:0] v);
      sat_inc = (v == afs_pkg::POS_MAX) ? v : v + afs_pkg::POS_ONE;
   endfunction : sat_inc

   ////////////////////////////////////////////////////////////////////////
   // State

   afs_pkg::afs_state_s s_reg;
   afs_pkg::afs_state_s s_next;

   afs_pkg::afs_ctrl_s ctrl;
   afs_pkg::afs_ext_t wl;
   afs_pkg::afs_ext_t off1;
   afs_pkg::afs_ext_t off2;
   afs_pkg::afs_ext_t base;
   afs_pkg::afs_ext_t gap;
   afs_pkg::afs_ext_t half_len;
   afs_pkg::afs_ext_t s1;
   afs_pkg::afs_ext_t s2;
   afs_pkg::afs_ext_t pos;
   afs_pkg::afs_ext_t start_sel;
   logic [afs_pkg::POS_W-1:0] new_half;
   logic [afs_pkg::POS_W-1:0] new_frame;
   logic [4:0] wmsb;
   logic [31:0] smp_l;
   logic [31:0] smp_r;
   logic is_rj;
   logic is_dsp;
   logic cap_rise;
   logic shift;
   logic wchg;
   logic rise;
   logic slot_eff;
   logic use_frame;
   logic rj_ok;
   logic left_half;
   logic act1;
   logic act2;
   logic act;
   logic sel_left;
   logic out_bit;
   logic [31:0] rd_mux;

   assign ctrl = s_reg.ctrl;
   assign is_rj = (ctrl.mode == afs_pkg::FR_RJ);
   assign is_dsp = (ctrl.mode == afs_pkg::FR_DSP);
   assign wl = afs_pkg::afs_wlen(ctrl.wlen);
   assign wmsb = 5'(wl - 11'h001);
   assign off1 = {3'h0, s_reg.ofs1};
   assign off2 = {3'h0, s_reg.ofs2};

   ////////////////////////////////////////////////////////////////////////
   // Bit clock edges and frame position

   // DSP captures on falling edges, the others on rising; inversion flips both
   assign cap_rise = ~(is_dsp ^ ctrl.bclk_inv);
   // Output changes on the opposite edge so a bit is valid at capture
   assign shift = (s_reg.bclk_s != s_reg.bclk_d) && (s_reg.bclk_s == ~cap_rise);
   assign wchg = (s_reg.wclk_s != s_reg.wclk_d);
   assign rise = wchg && s_reg.wclk_s;
   assign new_half = wchg ? afs_pkg::POS_ONE : sat_inc(s_reg.pos_half);
   assign new_frame = rise ? afs_pkg::POS_ONE : sat_inc(s_reg.pos_frame);
   assign smp_l = rise ? s_reg.left : s_reg.sh_l;
   assign smp_r = rise ? s_reg.right : s_reg.sh_r;

   ////////////////////////////////////////////////////////////////////////
   // Channel windows

   assign slot_eff = ctrl.slot_en && !is_rj;
   // Slot modes and DSP count from the word clock rise only
   assign use_frame = slot_eff || is_dsp;
   assign base = (ctrl.mode == afs_pkg::FR_I2S) ? 11'h002 : 11'h001;
   assign half_len = {1'b0, s_reg.wclk_s ? s_reg.len_hi : s_reg.len_lo};
   assign rj_ok = half_len >= wl;

   // Right-justified ends on the last capture edge of the previous same half
   always_comb begin
      if (is_rj) begin
         s1 = half_len - wl + 11'h001;
      end else begin
         s1 = off1 + base;
      end
   end

   // Gap from first LSB to second MSB
   always_comb begin
      if (!slot_eff) begin
         gap = 11'h000;
      end else if (is_dsp) begin
         gap = (off2 == 11'h000) ? 11'h000 : off2 - 11'h001;
      end else begin
         gap = off2;
      end
   end

   assign s2 = s1 + wl + gap;
   assign pos = {1'b0, use_frame ? new_frame : new_half};
   // Half framings: left in the high half (low half for I2S), swapped on request
   assign left_half = ((ctrl.mode == afs_pkg::FR_I2S) ? ~s_reg.wclk_s : s_reg.wclk_s)
      ^ ctrl.swap;
   assign act1 = in_win(pos, s1, wl) && (!is_rj || rj_ok);
   assign act2 = use_frame && in_win(pos, s2, wl);
   assign act = act1 || act2;
   assign sel_left = use_frame ? (act1 ? ~ctrl.swap : ctrl.swap)
      : left_half;
   assign start_sel = act1 ? s1 : s2;
   assign out_bit = bit_of(sel_left ? smp_l : smp_r, pos, start_sel, wl);

   ////////////////////////////////////////////////////////////////////////
   // Register read mux

   always_comb begin
      case (ADDR_I)
         afs_pkg::REG_CTRL: rd_mux = {24'h000000, s_reg.ctrl};
         afs_pkg::REG_OFS1: rd_mux = {24'h000000, s_reg.ofs1};
         afs_pkg::REG_OFS2: rd_mux = {24'h000000, s_reg.ofs2};
         afs_pkg::REG_LEFT: rd_mux = s_reg.left;
         afs_pkg::REG_RIGHT: rd_mux = s_reg.right;
         afs_pkg::REG_STAT: rd_mux = {6'h00, s_reg.frame_len, s_reg.frame_cnt};
         default: rd_mux = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_next = s_reg;
      if (CE_I) begin
         s_next.bclk_m = BCLK_I;
         s_next.bclk_s = s_reg.bclk_m;
         s_next.bclk_d = s_reg.bclk_s;
         s_next.wclk_m = WCLK_I;
         s_next.wclk_s = s_reg.wclk_m;
         s_next.rdata = RD_I ? rd_mux : 32'h00000000;
         if (WR_I) begin
            case (ADDR_I)
               afs_pkg::REG_CTRL: s_next.ctrl = WDATA_I[7:0];
               afs_pkg::REG_OFS1: s_next.ofs1 = WDATA_I[7:0];
               afs_pkg::REG_OFS2: s_next.ofs2 = WDATA_I[7:0];
               afs_pkg::REG_LEFT: s_next.left = WDATA_I;
               afs_pkg::REG_RIGHT: s_next.right = WDATA_I;
               default: s_next.rdata = s_next.rdata;
            endcase
         end
         if (shift) begin
            s_next.wclk_d = s_reg.wclk_s;
            s_next.pos_half = new_half;
            s_next.pos_frame = new_frame;
            if (wchg) begin
               if (s_reg.wclk_s) begin
                  s_next.len_lo = s_reg.pos_half;
               end else begin
                  s_next.len_hi = s_reg.pos_half;
               end
            end
            if (rise) begin
               s_next.sh_l = s_reg.left;
               s_next.sh_r = s_reg.right;
               s_next.frame_len = s_reg.pos_frame;
               s_next.frame_cnt = s_reg.frame_cnt + 16'h0001;
            end
            s_next.dout = act && out_bit;
            s_next.oe = act || !ctrl.tri_en;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         s_reg <= afs_pkg::ST_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign RDATA_O = s_reg.rdata;
   assign DOUT_O = s_reg.dout;
   assign DOUT_OE_O = s_reg.oe;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   logic lm;
   logic rm;
   logic slm;
   logic srm;
   logic sll;
   logic step;
   assign lm = s_reg.left[wmsb];
   assign rm = s_reg.right[wmsb];
   assign slm = s_reg.sh_l[wmsb];
   assign srm = s_reg.sh_r[wmsb];
   assign sll = s_reg.sh_l[0];
   assign step = CE_I && shift;

   AST_LJ_FIRST: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      (step && rise && ctrl.mode == afs_pkg::FR_LJ && !ctrl.slot_en && !ctrl.swap
      && s_reg.ofs1 == 8'h00) |=> (DOUT_OE_O && DOUT_O == $past(lm)))
      else $error("LJ left MSB missing after word clock rise");

   AST_LJ_SWAP: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      (step && rise && ctrl.mode == afs_pkg::FR_LJ && !ctrl.slot_en && ctrl.swap
      && s_reg.ofs1 == 8'h00) |=> (DOUT_OE_O && DOUT_O == $past(rm)))
      else $error("LJ swapped right MSB missing");

   AST_LJ_SLOT: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      (step && !wchg && ctrl.mode == afs_pkg::FR_LJ && ctrl.slot_en && !ctrl.swap
      && s_reg.ofs1 == 8'h00 && {1'b0, new_frame} == 11'h001 + wl + off2)
      |=> (DOUT_OE_O && DOUT_O == $past(srm)))
      else $error("LJ slot right MSB misplaced");

   AST_I2S_LEFT: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      (step && ctrl.mode == afs_pkg::FR_I2S && !ctrl.slot_en && !ctrl.swap
      && s_reg.ofs1 == 8'h00 && !s_reg.wclk_s && new_half == 10'h002)
      |=> (DOUT_OE_O && DOUT_O == $past(slm)))
      else $error("I2S left MSB not on second edge");

   AST_DSP_B2B: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      (step && !wchg && is_dsp && !ctrl.slot_en && !ctrl.swap && s_reg.ofs1 == 8'h00
      && {1'b0, new_frame} == wl + 11'h001) |=> (DOUT_OE_O && DOUT_O == $past(srm)))
      else $error("DSP right word not back to back");

   AST_DSP_SLOT: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      (step && !wchg && is_dsp && ctrl.slot_en && !ctrl.swap && s_reg.ofs1 == 8'h00
      && s_reg.ofs2 != 8'h00 && {1'b0, new_frame} == wl + off2)
      |=> (DOUT_OE_O && DOUT_O == $past(srm)))
      else $error("DSP slot right MSB misplaced");

   AST_RJ_LSB: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      (step && is_rj && !wchg && s_reg.wclk_s && !ctrl.swap && s_reg.len_hi >= wl[9:0]
      && new_half == s_reg.len_hi) |=> (DOUT_OE_O && DOUT_O == $past(sll)))
      else $error("RJ left LSB not before word clock fall");

   AST_RJ_NOSLOT: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      (step && is_rj && ctrl.slot_en && ctrl.tri_en && !in_win(pos, s1, wl))
      |=> !DOUT_OE_O)
      else $error("Slot mode active in right-justified framing");

   AST_TRI: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      (step && !act && ctrl.tri_en) |=> !DOUT_OE_O)
      else $error("Output driven in an empty cycle");

   AST_LOW: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      (step && !act && !ctrl.tri_en) |=> (DOUT_OE_O && !DOUT_O))
      else $error("Empty cycle not driven low");

   AST_SHIFT_ONLY: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      !step |=> ($stable(DOUT_O) && $stable(DOUT_OE_O)))
      else $error("Data changed away from a shift edge");

endmodule : afs_formatter

// [afs_host_model.sv]
// Host serial port model: makes bit and word clocks, captures serial data
`timescale 1ns/1ps
module afs_host_model #(
   parameter int HALF = 40
) (
   input wire logic cap_fall_i,
   output logic bclk_o,
   output logic wclk_o,
   input wire logic dout_i,
   input wire logic dout_oe_i
);
   logic cap_d [1:2*HALF];
   logic cap_oe [1:2*HALF];

   initial begin
      bclk_o = 1'b1;
      wclk_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frames of 2*HALF bit clocks, more than two 32-bit words; clocks idle between runs
   task automatic run_frames(input int n);
      bclk_o = ~cap_fall_i;
      #100;
      for (int f = 0; f < n; f++) begin
         for (int i = 0; i < 2 * HALF; i++) begin
            // Word clock moves together with the shift edge
            bclk_o = cap_fall_i;
            wclk_o = (i < HALF);
            #62.5;
            cap_d[i + 1] = dout_i;
            cap_oe[i + 1] = dout_oe_i;
            bclk_o = ~cap_fall_i;
            #62.5;
         end
      end
   endtask : run_frames
endmodule : afs_host_model

// [tb_audio_serial_frame_formatter.sv]
// Self-checking testbench of the serial audio frame formatter
`timescale 1ns/1ps
module tb_audio_serial_frame_formatter;
   localparam int HALF = 40;
   localparam logic [31:0] LEFT_W = 32'hA5C396F1;
   localparam logic [31:0] RIGHT_W = 32'h3C5AE10F;

   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [31:0] wdata = 32'h00000000;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic cap_fall = 1'b0;
   logic ce = 1'b1;
   logic [31:0] rdata;
   logic bclk;
   logic wclk;
   logic dout;
   logic dout_oe;
   int fail_count = 0;
   int total_checks = 0;

   always #4 sys_clk = ~sys_clk;

   afs_formatter dut (
      .SYS_CLK_I(sys_clk), .NRST_I(nrst), .CE_I(ce), .BCLK_I(bclk), .WCLK_I(wclk),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
      .DOUT_O(dout), .DOUT_OE_O(dout_oe)
   );

   afs_host_model #(.HALF(HALF)) host (
      .cap_fall_i(cap_fall), .bclk_o(bclk), .wclk_o(wclk), .dout_i(dout),
      .dout_oe_i(dout_oe)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : cmp

   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr_s <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd_s <= 1'b0;
      #1;
      v = rdata;
   endtask : rd

   // Configure, run two frames, check every capture slot of the second one
   task automatic run_chk(input logic [7:0] c, input logic [7:0] o1, input logic [7:0] o2);
      int wl;
      int sa;
      int sb;
      logic [31:0] wa;
      logic [31:0] wb;
      logic [1:0] e;
      logic [1:0] s;
      wl = (c[3:2] == 2'h3) ? 32 : 16 + 4 * int'(c[3:2]);
      wr(afs_pkg::REG_CTRL, {24'h000000, c});
      wr(afs_pkg::REG_OFS1, {24'h000000, o1});
      wr(afs_pkg::REG_OFS2, {24'h000000, o2});
      wr(afs_pkg::REG_LEFT, LEFT_W);
      wr(afs_pkg::REG_RIGHT, RIGHT_W);
      cap_fall <= (c[1:0] == 2'h3) ^ c[7];
      @(posedge sys_clk);
      host.run_frames(2);
      sa = int'(o1) + 1;
      sb = HALF + sa;
      if (c[1:0] == 2'h0) begin
         sa = HALF - wl + 1;
         sb = 2 * HALF - wl + 1;
      end else if (c[1:0] == 2'h2) begin
         sa = sa + 1;
         sb = sb + 1;
      end else if (c[1:0] == 2'h3) begin
         sb = sa + wl;
      end
      if (c[5] && c[1:0] != 2'h0) begin
         sb = sa + wl + int'(o2) - ((c[1:0] == 2'h3 && o2 != 8'h00) ? 1 : 0);
      end
      // I2S sends right in the high half unless swapped
      wa = (c[4] ^ (c[1:0] == 2'h2)) ? RIGHT_W : LEFT_W;
      wb = (c[4] ^ (c[1:0] == 2'h2)) ? LEFT_W : RIGHT_W;
      for (int n = 1; n <= 2 * HALF; n++) begin
         e = c[6] ? 2'h0 : 2'h2;
         if (n >= sa && n < sa + wl) begin
            e = {1'b1, wa[wl - 1 - (n - sa)]};
         end
         if (n >= sb && n < sb + wl) begin
            e = {1'b1, wb[wl - 1 - (n - sb)]};
         end
         s = host.cap_oe[n] ? {1'b1, host.cap_d[n]} : 2'h0;
         cmp({30'h0, s}, {30'h0, e});
      end
   endtask : run_chk

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] v;
      rd(afs_pkg::REG_CTRL, v);
      cmp(v, 32'h00000041);
      wr(afs_pkg::REG_OFS2, 32'hFFFFFFFF);
      rd(afs_pkg::REG_OFS2, v);
      cmp(v, 32'h000000FF);
      wr(3'h7, 32'hFFFFFFFF);
      rd(3'h7, v);
      cmp(v, 32'h00000000);
   endtask : t_regs

   // Writes while the clock enable is low must not land
   task automatic t_ce;
      logic [31:0] v;
      ce <= 1'b0;
      wr(afs_pkg::REG_OFS1, 32'h00000055);
      ce <= 1'b1;
      rd(afs_pkg::REG_OFS1, v);
      cmp(v, 32'h00000000);
   endtask : t_ce

   task automatic t_lj;
      run_chk(8'h41, 8'h01, 8'h00);
      run_chk(8'h51, 8'h01, 8'h00);
   endtask : t_lj

   task automatic t_wlen;
      for (int w = 0; w < 4; w++) begin
         run_chk({4'h0, 2'(w), 2'h1}, 8'h02, 8'h00);
      end
   endtask : t_wlen

   task automatic t_slot;
      run_chk(8'h61, 8'h00, 8'h01);
      run_chk(8'h71, 8'h00, 8'h01);
   endtask : t_slot

   task automatic t_i2s;
      run_chk(8'h42, 8'h00, 8'h00);
      run_chk(8'h42, 8'h02, 8'h00);
   endtask : t_i2s

   task automatic t_dsp;
      run_chk(8'h43, 8'h01, 8'h00);
      run_chk(8'h63, 8'h00, 8'h03);
      run_chk(8'h73, 8'h00, 8'h03);
   endtask : t_dsp

   task automatic t_rj;
      logic [31:0] v;
      run_chk(8'h68, 8'h05, 8'h03);
      rd(afs_pkg::REG_STAT, v);
      cmp({22'h000000, v[25:16]}, 32'h00000050);
   endtask : t_rj

   task automatic t_inv;
      run_chk(8'hC1, 8'h00, 8'h00);
      run_chk(8'hC3, 8'h01, 8'h00);
   endtask : t_inv

   task automatic summarize;
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_ce();
      t_lj();
      t_wlen();
      t_slot();
      t_i2s();
      t_dsp();
      t_rj();
      t_inv();
      summarize();
   end

   // About 32 frames of 10 us each are expected
   initial begin
      #600000;
      fail_count++;
      summarize();
   end
endmodule : tb_audio_serial_frame_formatter
